// ==== sim/fspc_cpu_model.sv ====
// processor core model: register port and store/load program instructions
`timescale 1ns/1ns
module fspc_cpu_model (
  input  wire logic        i_mclk,
  input  wire logic [7:0]  i_io_rdata,
  output logic      [7:0]  o_io_addr,
  output logic             o_io_wr,
  output logic             o_io_rd,
  output logic      [7:0]  o_io_wdata,
  output logic             o_spm,
  output logic             o_lpm,
  output logic      [16:0] o_z,
  output logic      [7:0]  o_r0,
  output logic      [7:0]  o_r1
);
  // ========
  // bus cycles, changed at the falling edge
  initial begin
    {o_io_wr, o_io_rd, o_spm, o_lpm} = 4'h0;
    {o_io_addr, o_io_wdata, o_z, o_r1, o_r0} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_mclk);
    o_io_addr = a;
    o_io_wdata = v;
    o_io_wr = 1'b1;
    @(negedge i_mclk);
    o_io_wr = 1'b0;
    o_io_wdata = ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge i_mclk);
    o_io_addr = a;
    o_io_rd = 1'b1;
    @(negedge i_mclk);
    o_io_rd = 1'b0;
    v = i_io_rdata;
  endtask
  task automatic spm(input logic [16:0] z, input logic [7:0] hi, input logic [7:0] lo);
    @(negedge i_mclk);
    o_z = {z[16:1], 1'b0};
    {o_r1, o_r0} = {hi, lo};
    o_spm = 1'b1;
    @(negedge i_mclk);
    o_spm = 1'b0;
    {o_r1, o_r0} = ~{hi, lo};
  endtask
  task automatic load_program_instruction(input logic [16:0] z);
    @(negedge i_mclk);
    o_z = z;
    o_lpm = 1'b1;
    @(negedge i_mclk);
    o_lpm = 1'b0;
  endtask
  // poll until store-enable reads clear
  task automatic idle();
    logic [7:0] v;
    int n;
    v = 8'h01;
    n = 0;
    while (v[0] !== 1'b0 && n < 300) begin
      rd(8'h37, v);
      n++;
    end
  endtask
endmodule

// ==== sim/fspc_ctrl_properties.sv ====
// port checker for the flash self-program control block
`timescale 1ns/1ns
module fspc_ctrl_properties #(
  parameter int unsigned Z_W = 17
) (
  input wire logic           i_mclk,
  input wire logic           i_nrst,
  input wire logic [7:0]     i_io_addr,
  input wire logic           i_io_wr,
  input wire logic           i_gie,
  input wire logic           i_spm_exec,
  input wire logic           i_lpm_exec,
  input wire logic [Z_W-1:0] i_z_ptr,
  input wire logic [7:0]     i_r0,
  input wire logic [7:0]     i_r1,
  input wire logic           o_irq_req,
  input wire logic           o_cpu_halt,
  input wire logic           o_section_blocked,
  input wire logic           o_buf_wr,
  input wire logic [6:0]     o_buf_word_addr,
  input wire logic [15:0]    o_buf_data,
  input wire logic           o_buf_discard,
  input wire logic           o_page_erase,
  input wire logic           o_page_write,
  input wire logic [Z_W-9:0] o_page_addr,
  input wire logic           o_lock_wr,
  input wire logic [7:0]     o_lock_data,
  input wire logic           o_lpm_valid,
  input wire logic           o_xrow_ext,
  input wire logic [1:0]     o_xrow_sel
);
  // ========
  // clocks since the last control register write, saturating
  logic [2:0] since_q;
  logic [2:0] since_d;
  assign since_d = (i_io_wr && i_io_addr == 8'h37) ? 3'h0 :
                   (since_q == 3'h7) ? 3'h7 : since_q + 3'h1;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst)
      since_q <= 3'h7;
    else
      since_q <= since_d;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // ========
  // properties
  property p_irq; o_irq_req |-> $past(i_gie) && !o_cpu_halt; endproperty
  a_irq: assert property (p_irq) else $error("ready request without flag");
  property p_busy_set; $rose(o_section_blocked) |-> (o_page_erase || o_page_write
    || $past(o_page_erase) || $past(o_page_write)); endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy without operation");
  property p_busy_clr; $fell(o_section_blocked) |-> ($past(i_spm_exec) || $past(i_spm_exec, 2));
  endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("busy cleared without store");
  property p_discard; o_buf_discard |-> ($past(i_io_wr) || $past(i_spm_exec)); endproperty
  a_discard: assert property (p_discard) else $error("discard without cause");
  property p_lock; o_lock_wr |-> $past(i_spm_exec) && $past(since_q) <= 3'h3
    && o_lock_data == $past(i_r0); endproperty
  a_lock: assert property (p_lock) else $error("bad lock write");
  property p_fill; o_buf_wr |-> $past(i_spm_exec) && $past(since_q) <= 3'h3
    && o_buf_data == {$past(i_r1), $past(i_r0)} && o_buf_word_addr == $past(i_z_ptr[7:1]);
  endproperty
  a_fill: assert property (p_fill) else $error("bad buffer write");
  property p_page; (o_page_erase || o_page_write) |-> $past(since_q) <= 3'h3
    && o_page_addr == $past(i_z_ptr[Z_W-1:8]); endproperty
  a_page: assert property (p_page) else $error("bad page operation");
  property p_halt; $rose(o_cpu_halt) |-> (o_page_erase || o_page_write
    || $past(o_page_erase) || $past(o_page_write)); endproperty
  a_halt: assert property (p_halt) else $error("halt without operation");
  property p_lpm; o_lpm_valid |-> $past(i_lpm_exec) && $past(since_q) <= 3'h2; endproperty
  a_lpm: assert property (p_lpm) else $error("load answer outside window");
  property p_xrow; o_xrow_sel != 2'h0 |-> o_xrow_ext; endproperty
  a_xrow: assert property (p_xrow) else $error("row select outside extended mode");
  c_lock: cover property (o_lock_wr);
  c_halt: cover property (o_cpu_halt && o_page_erase);
  c_discard: cover property (o_buf_discard);
  c_lpm: cover property (o_lpm_valid);
endmodule

// ==== sim/test_flash_self_program_control.sv ====
// self-checking bench for the flash self-program control block
`timescale 1ns/1ns
module test_flash_self_program_control;
  localparam logic [7:0] LOCK_V = 8'h5A;
  localparam logic [7:0] FUSE_V = 8'hC3;
  // arbitrary signature byte
  localparam logic [7:0] SIG_V = 8'h3C;
  localparam logic [7:0] BAD [7] = '{8'h07, 8'h0F, 8'h13, 8'h1F, 8'h02, 8'h10, 8'h29};
  logic        i_mclk, i_nrst, i_io_wr, i_io_rd, i_gie, i_spm_exec, i_lpm_exec;
  logic        o_irq_req, o_cpu_halt, o_section_blocked, o_buf_wr, o_buf_discard;
  logic        o_page_erase, o_page_write, o_lock_wr, o_lpm_valid, o_xrow_ext;
  logic [7:0]  i_io_addr, i_io_wdata, o_io_rdata, i_r0, i_r1, o_lock_data, o_lpm_data, d;
  logic [16:0] i_z_ptr;
  logic [15:0] o_buf_data;
  logic [8:0]  o_page_addr;
  logic [6:0]  o_buf_word_addr;
  logic [1:0]  o_xrow_sel;
  int          num_errors, comparisons, cycles, n;
  fspc_ctrl #(.WRITE_CYCLES(20), .ERASE_CYCLES(40)) dut (
    .i_mclk, .i_nrst, .i_io_addr, .i_io_wr, .i_io_rd, .i_io_wdata, .o_io_rdata, .i_gie,
    .i_spm_exec, .i_lpm_exec, .i_z_ptr, .i_r0, .i_r1, .i_lock_bits(LOCK_V),
    .i_fuse_bits(FUSE_V), .i_sig_byte(SIG_V), .o_irq_req, .o_cpu_halt, .o_section_blocked,
    .o_buf_wr, .o_buf_word_addr, .o_buf_data, .o_buf_discard, .o_page_erase, .o_page_write,
    .o_page_addr, .o_lock_wr, .o_lock_data, .o_lpm_valid, .o_lpm_data, .o_xrow_ext, .o_xrow_sel);
  fspc_cpu_model cpu (
    .i_mclk, .i_io_rdata(o_io_rdata), .o_io_addr(i_io_addr), .o_io_wr(i_io_wr),
    .o_io_rd(i_io_rd), .o_io_wdata(i_io_wdata), .o_spm(i_spm_exec), .o_lpm(i_lpm_exec),
    .o_z(i_z_ptr), .o_r0(i_r0), .o_r1(i_r1));
  // ========
  // clock, timeout and reporting
  always #20 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ========
  // scenarios
  task automatic t_reset();
    cpu.rd(8'h37, d);
    chk(d, 8'h00);
    cpu.rd(8'h75, d);
    chk(d, 8'h0A);
    cpu.rd(8'h50, d);
    chk(d, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_rww();
    cpu.wr(8'h37, 8'h03);
    repeat (3) @(negedge i_mclk);
    cpu.spm(17'h00500, 8'h00, 8'h00);
    chk(o_page_erase, 1'b0);
    cpu.rd(8'h37, d);
    chk(d, 8'h00);
    cpu.wr(8'h37, 8'h03);
    repeat (2) @(negedge i_mclk);
    cpu.spm(17'h00500, 8'h00, 8'h00);
    chk({o_page_erase, o_cpu_halt, o_section_blocked, o_page_addr}, {3'b101, 9'h005});
    cpu.wr(8'h37, 8'h11);
    cpu.rd(8'h37, d);
    chk(d, 8'h43);
    cpu.idle();
    chk(o_section_blocked, 1'b1);
    cpu.wr(8'h37, 8'h11);
    cpu.spm(17'h00000, 8'h00, 8'h00);
    @(negedge i_mclk);
    chk(o_section_blocked, 1'b0);
    $display("rww erase test done");
  endtask
  task automatic t_halt();
    cpu.wr(8'h37, 8'h03);
    cpu.spm(17'h1F400, 8'h00, 8'h00);
    chk({o_page_erase, o_cpu_halt, o_section_blocked}, 3'b110);
    n = 0;
    while (o_cpu_halt === 1'b1 && n < 200) begin
      @(negedge i_mclk);
      n++;
    end
    chk(n >= 39 && n <= 48, 1'b1);
    cpu.rd(8'h37, d);
    chk(d, 8'h00);
    $display("halt test done");
  endtask
  task automatic t_write();
    cpu.wr(8'h37, 8'h05);
    cpu.spm(17'h00700, 8'hFF, 8'hFF);
    chk({o_page_write, o_cpu_halt, o_section_blocked, o_page_addr}, {3'b101, 9'h007});
    cpu.idle();
    cpu.rd(8'h37, d);
    chk(d, 8'h40);
    cpu.wr(8'h37, 8'h01);
    cpu.spm(17'h003A4, 8'h12, 8'h34);
    chk({o_buf_wr, o_buf_word_addr, o_buf_data}, {1'b1, 7'h52, 16'h1234});
    @(negedge i_mclk);
    chk(o_section_blocked, 1'b0);
    cpu.rd(8'h37, d);
    chk(d, 8'h00);
    cpu.wr(8'h37, 8'h11);
    chk(o_buf_discard, 1'b1);
    $display("write and fill test done");
  endtask
  task automatic t_lock();
    cpu.wr(8'h37, 8'h09);
    cpu.load_program_instruction(17'h00000);
    chk({o_lpm_valid, o_lpm_data}, {1'b1, LOCK_V});
    cpu.wr(8'h37, 8'h09);
    cpu.load_program_instruction(17'h00001);
    chk({o_lpm_valid, o_lpm_data}, {1'b1, FUSE_V});
    cpu.wr(8'h37, 8'h21);
    cpu.load_program_instruction(17'h00000);
    chk({o_lpm_valid, o_lpm_data}, {1'b1, SIG_V});
    cpu.spm(17'h00700, 8'h12, 8'h34);
    chk({o_buf_wr, o_page_erase, o_page_write, o_lock_wr}, 4'h0);
    repeat (3) @(negedge i_mclk);
    cpu.wr(8'h37, 8'h09);
    cpu.spm(17'h00000, 8'h00, 8'hA5);
    chk({o_lock_wr, o_lock_data, o_cpu_halt}, {1'b1, 8'hA5, 1'b0});
    cpu.idle();
    cpu.rd(8'h37, d);
    chk(d, 8'h00);
    $display("lock test done");
  endtask
  task automatic t_cmd();
    for (int k = 0; k < 7; k++) begin
      cpu.wr(8'h37, BAD[k]);
      cpu.rd(8'h37, d);
      chk(d, 8'h00);
    end
    cpu.wr(8'h37, 8'h87);
    cpu.rd(8'h37, d);
    chk(d, 8'h80);
    i_gie = 1'b1;
    @(negedge i_mclk);
    chk(o_irq_req, 1'b1);
    cpu.wr(8'h37, 8'h81);
    @(negedge i_mclk);
    chk(o_irq_req, 1'b0);
    repeat (5) @(negedge i_mclk);
    chk(o_irq_req, 1'b1);
    i_gie = 1'b0;
    repeat (2) @(negedge i_mclk);
    chk(o_irq_req, 1'b0);
    cpu.wr(8'h37, 8'h00);
    $display("command test done");
  endtask
  task automatic t_xrow();
    for (int s = 0; s < 4; s++) begin
      cpu.wr(8'h75, {2'b01, s[1:0], 4'h0});
      @(negedge i_mclk);
      chk({o_xrow_ext, o_xrow_sel}, {1'b1, s[1:0]});
    end
    cpu.wr(8'h75, 8'h3F);
    @(negedge i_mclk);
    chk({o_xrow_ext, o_xrow_sel}, 3'h0);
    cpu.rd(8'h75, d);
    chk(d, 8'h3F);
    $display("extra row test done");
  endtask
  initial begin
    i_mclk = 1'b0;
    i_nrst = 1'b0;
    i_gie = 1'b0;
    repeat (10) @(negedge i_mclk);
    i_nrst = 1'b1;
    t_reset();
    t_rww();
    t_halt();
    t_write();
    t_lock();
    t_cmd();
    t_xrow();
    end_sim();
  end
endmodule
bind fspc_ctrl fspc_ctrl_properties #(.Z_W(Z_W)) u_props (
  .i_mclk, .i_nrst, .i_io_addr, .i_io_wr, .i_gie, .i_spm_exec, .i_lpm_exec, .i_z_ptr, .i_r0,
  .i_r1, .o_irq_req, .o_cpu_halt, .o_section_blocked, .o_buf_wr, .o_buf_word_addr,
  .o_buf_data, .o_buf_discard, .o_page_erase, .o_page_write, .o_page_addr, .o_lock_wr,
  .o_lock_data, .o_lpm_valid, .o_xrow_ext, .o_xrow_sel);

// ==== src/fspc_ctrl.sv ====
// flash self-program control: command arming, buffer fill, erase, write, lock
`timescale 1ns/1ns
`include "fspc_defs.svh"
module fspc_ctrl
  import fspc_pkg::*;
#(
  parameter int unsigned Z_W           = 17,
  parameter int unsigned RWW_PAGES     = `FSPC_RWW_PAGES,
  parameter int unsigned WRITE_CYCLES  = `FSPC_WRITE_CYCLES,
  parameter int unsigned ERASE_CYCLES  = `FSPC_ERASE_CYCLES
) (
  input  wire logic             i_mclk,
  input  wire logic             i_nrst,
  input  wire logic [7:0]       i_io_addr,
  input  wire logic             i_io_wr,
  input  wire logic             i_io_rd,
  input  wire logic [7:0]       i_io_wdata,
  output logic      [7:0]       o_io_rdata,
  input  wire logic             i_gie,
  input  wire logic             i_spm_exec,
  input  wire logic             i_lpm_exec,
  input  wire logic [Z_W-1:0]   i_z_ptr,
  input  wire logic [7:0]       i_r0,
  input  wire logic [7:0]       i_r1,
  input  wire logic [7:0]       i_lock_bits,
  input  wire logic [7:0]       i_fuse_bits,
  input  wire logic [7:0]       i_sig_byte,
  output logic                  o_irq_req,
  output logic                  o_cpu_halt,
  output logic                  o_section_blocked,
  output logic                  o_buf_wr,
  output logic      [6:0]       o_buf_word_addr,
  output logic      [15:0]      o_buf_data,
  output logic                  o_buf_discard,
  output logic                  o_page_erase,
  output logic                  o_page_write,
  output logic      [Z_W-9:0]   o_page_addr,
  output logic                  o_lock_wr,
  output logic      [7:0]       o_lock_data,
  output logic                  o_lpm_valid,
  output logic      [7:0]       o_lpm_data,
  output logic                  o_xrow_ext,
  output logic      [1:0]       o_xrow_sel
);

  localparam int unsigned PAGE_W = Z_W - 8;
  localparam logic        IRQ_EN_RST = 1'(`FSPC_CTRL_RESET >> `FSPC_BIT_IRQ_EN);
  // counter wide enough for the longer of the two operation times
  localparam int unsigned TIMER_W = $clog2(((ERASE_CYCLES > WRITE_CYCLES) ? ERASE_CYCLES
                                            : WRITE_CYCLES) + 1);

  // =====================================================================
  // command decode
  function automatic fspc_cmd_t cmd_decode(input logic [5:0] bits);
    fspc_cmd_t c;
    c = FSPC_CMD_NONE;
    case (bits[4:0])
      `FSPC_PAT_REEN:  c = bits[5] ? FSPC_CMD_NONE : FSPC_CMD_REEN;
      `FSPC_PAT_LOCK:  c = bits[5] ? FSPC_CMD_NONE : FSPC_CMD_LOCK;
      `FSPC_PAT_WRITE: c = bits[5] ? FSPC_CMD_NONE : FSPC_CMD_WRITE;
      `FSPC_PAT_ERASE: c = bits[5] ? FSPC_CMD_NONE : FSPC_CMD_ERASE;
      `FSPC_PAT_FILL:  c = bits[5] ? FSPC_CMD_SIG : FSPC_CMD_FILL;
      default:         c = FSPC_CMD_NONE;
    endcase
    return c;
  endfunction

  // commands whose arming also opens the load window
  function automatic logic is_load_cmd(input fspc_cmd_t c);
    return (c == FSPC_CMD_LOCK) || (c == FSPC_CMD_SIG);
  endfunction

  // =====================================================================
  // state
  fspc_state_t       state_q;
  fspc_state_t       state_d;
  fspc_cmd_t         cmd_q;
  logic [2:0]        win_q;
  logic [1:0]        lwin_q;
  logic              irq_en_q;
  logic              busy_q;
  logic              dirty_q;
  logic              halt_q;
  logic [7:0]        xrow_q;
  logic              op_done;

  // =====================================================================
  // register port decode
  wire        ctrl_wr   = i_io_wr && (i_io_addr == `FSPC_CTRL_ADDR);
  wire        xrow_wr   = i_io_wr && (i_io_addr == `FSPC_XROW_ADDR);
  wire        ctrl_rd   = i_io_rd && (i_io_addr == `FSPC_CTRL_ADDR);
  wire        xrow_rd   = i_io_rd && (i_io_addr == `FSPC_XROW_ADDR);
  wire [5:0]  cmd_bits  = i_io_wdata[`FSPC_BIT_SIG_RD:`FSPC_BIT_STORE_EN];
  wire fspc_cmd_t new_cmd = cmd_decode(cmd_bits);

  // commands are taken only when no operation is running
  wire        arm       = ctrl_wr && (state_q != FSPC_BUSY)
                          && (new_cmd != FSPC_CMD_NONE);
  // a rewrite in the same cycle as a store re-arms and drops the store
  wire        spm_hit   = (state_q == FSPC_ARMED) && i_spm_exec
                          && !arm;
  wire        lpm_hit   = (lwin_q != 2'h0) && i_lpm_exec
                          && is_load_cmd(cmd_q);
  // the window closes on the fourth edge after the write
  wire        win_end   = (state_q == FSPC_ARMED) && (win_q == 3'h1)
                          && !i_spm_exec && !arm;
  wire        discard   = ctrl_wr && i_io_wdata[`FSPC_BIT_REEN] && dirty_q;

  // pages at and above the limit belong to the halting section
  wire [PAGE_W-1:0] page = i_z_ptr[Z_W-1:8];
  wire        in_rww    = (32'(page) < RWW_PAGES);

  wire        hit_fill  = spm_hit && (cmd_q == FSPC_CMD_FILL);
  wire        hit_erase = spm_hit && (cmd_q == FSPC_CMD_ERASE);
  wire        hit_write = spm_hit && (cmd_q == FSPC_CMD_WRITE);
  wire        hit_lock  = spm_hit && (cmd_q == FSPC_CMD_LOCK);
  wire        hit_reen  = spm_hit && (cmd_q == FSPC_CMD_REEN);
  wire        hit_pgop  = hit_erase || hit_write;
  wire        op_start  = hit_pgop || hit_lock;

  // =====================================================================
  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      FSPC_IDLE: begin
        if (arm) begin
          state_d = FSPC_ARMED;
        end
      end
      FSPC_ARMED: begin
        if (arm) begin
          state_d = FSPC_ARMED;
        end else if (op_start) begin
          state_d = FSPC_BUSY;
        end else if (spm_hit || win_end) begin
          state_d = FSPC_IDLE;
        end
      end
      FSPC_BUSY: begin
        if (op_done) begin
          state_d = FSPC_IDLE;
        end
      end
      default: state_d = FSPC_IDLE;
    endcase
  end

  // =====================================================================
  // sequencer registers
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= FSPC_IDLE;
      cmd_q   <= FSPC_CMD_NONE;
      win_q   <= 3'h0;
      lwin_q  <= 2'h0;
    end else begin
      state_q <= state_d;
      if (arm) begin
        cmd_q  <= new_cmd;
        win_q  <= `FSPC_STORE_WINDOW;
        lwin_q <= is_load_cmd(new_cmd) ? `FSPC_LOAD_WINDOW : 2'h0;
      end else begin
        // an expired or consumed arm forgets its command
        if (state_d == FSPC_IDLE) begin
          cmd_q <= FSPC_CMD_NONE;
        end
        if (win_q != 3'h0) begin
          win_q <= win_q - 3'h1;
        end
        if (lwin_q != 2'h0) begin
          lwin_q <= lwin_q - 2'h1;
        end
      end
    end
  end

  // =====================================================================
  // section busy, halt and buffer bookkeeping
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_q  <= 1'b0;
      halt_q  <= 1'b0;
      dirty_q <= 1'b0;
    end else begin
      if (hit_pgop && in_rww) begin
        busy_q <= 1'b1;
      end else if (hit_reen || hit_fill) begin
        busy_q <= 1'b0;
      end
      if (hit_pgop && !in_rww) begin
        halt_q <= 1'b1;
      end else if (op_done) begin
        halt_q <= 1'b0;
      end
      // filled words stay until a page operation takes them or a re-enable drops them
      if (hit_fill) begin
        dirty_q <= 1'b1;
      end else if (discard || hit_pgop) begin
        dirty_q <= 1'b0;
      end
    end
  end

  // =====================================================================
  // control and extra-row registers
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_en_q <= IRQ_EN_RST;
      xrow_q   <= `FSPC_XROW_RESET;
    end else begin
      if (ctrl_wr) begin
        irq_en_q <= i_io_wdata[`FSPC_BIT_IRQ_EN];
      end
      if (xrow_wr) begin
        xrow_q <= i_io_wdata;
      end
    end
  end

  // =====================================================================
  // read-back and extra-row decode
  // store-enable reads high from arming until the operation ends
  wire       store_enable_rd = (state_q != FSPC_IDLE);
  wire [7:0] ctrl_val = {irq_en_q,
                         busy_q,
                         cmd_q == FSPC_CMD_SIG,
                         cmd_q == FSPC_CMD_REEN,
                         cmd_q == FSPC_CMD_LOCK,
                         cmd_q == FSPC_CMD_WRITE,
                         cmd_q == FSPC_CMD_ERASE,
                         store_enable_rd};
  wire [7:0] rd_val   = ctrl_rd ? ctrl_val : (xrow_rd ? xrow_q : 8'h00);

  // reserved bits of the extra-row register are plain storage
  wire [7:0] xrow_nx  = xrow_wr ? i_io_wdata : xrow_q;
  wire       ext_nx   = xrow_nx[`FSPC_BIT_XROW_EXT];
  wire [1:0] sel_nx   = ext_nx ? xrow_nx[`FSPC_XROW_SEL_HI:`FSPC_XROW_SEL_LO]
                               : 2'h0;

  wire [7:0] lpm_val  = (cmd_q == FSPC_CMD_SIG) ? i_sig_byte
                        : (i_z_ptr[0] ? i_fuse_bits : i_lock_bits);

  // =====================================================================
  // level outputs
  wire       irq_nx     = irq_en_q && i_gie && (state_q == FSPC_IDLE);
  wire       halt_nx    = (hit_pgop && !in_rww) || (halt_q && !op_done);
  wire       blocked_nx = (hit_pgop && in_rww)
                          || (busy_q && !hit_reen && !hit_fill);

  // =====================================================================
  // outputs
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_io_rdata        <= 8'h00;
      o_irq_req         <= 1'b0;
      o_cpu_halt        <= 1'b0;
      o_section_blocked <= 1'b0;
      o_buf_wr          <= 1'b0;
      o_buf_word_addr   <= 7'h00;
      o_buf_data        <= 16'h0000;
      o_buf_discard     <= 1'b0;
      o_page_erase      <= 1'b0;
      o_page_write      <= 1'b0;
      o_page_addr       <= '0;
      o_lock_wr         <= 1'b0;
      o_lock_data       <= 8'h00;
      o_lpm_valid       <= 1'b0;
      o_lpm_data        <= 8'h00;
      o_xrow_ext        <= 1'b0;
      o_xrow_sel        <= 2'h0;
    end else begin
      o_io_rdata        <= rd_val;
      o_irq_req         <= irq_nx;
      o_cpu_halt        <= halt_nx;
      o_section_blocked <= blocked_nx;
      o_buf_wr          <= hit_fill;
      o_buf_discard     <= discard;
      o_page_erase      <= hit_erase;
      o_page_write      <= hit_write;
      o_lock_wr         <= hit_lock;
      o_lpm_valid       <= lpm_hit;
      // data outputs keep their last value between pulses
      if (hit_fill) begin
        o_buf_word_addr <= i_z_ptr[7:1];
        o_buf_data      <= {i_r1, i_r0};
      end
      if (hit_pgop) begin
        o_page_addr     <= page;
      end
      if (hit_lock) begin
        o_lock_data     <= i_r0;
      end
      if (lpm_hit) begin
        o_lpm_data      <= lpm_val;
      end
      o_xrow_ext        <= ext_nx;
      o_xrow_sel        <= sel_nx;
    end
  end

  // =====================================================================
  // operation duration; lock writes reuse the write time and never halt
  fspc_op_timer #(
    .CNT_W        (TIMER_W),
    .WRITE_CYCLES (WRITE_CYCLES),
    .ERASE_CYCLES (ERASE_CYCLES)
  ) u_timer (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_start (op_start),
    .i_erase (hit_erase),
    .o_done  (op_done)
  );

endmodule

// ==== src/fspc_defs.svh ====
// constants for the flash self-program control block
`ifndef FSPC_DEFS_SVH
`define FSPC_DEFS_SVH

// =====================================================================
// register addresses on the processor's I/O port
`define FSPC_CTRL_ADDR        8'h37
`define FSPC_XROW_ADDR        8'h75

// =====================================================================
// store_program_control field positions
`define FSPC_BIT_IRQ_EN       7
`define FSPC_BIT_BUSY         6
`define FSPC_BIT_SIG_RD       5
`define FSPC_BIT_REEN         4
`define FSPC_BIT_LOCK_SET     3
`define FSPC_BIT_PG_WRITE     2
`define FSPC_BIT_PG_ERASE     1
`define FSPC_BIT_STORE_EN     0

// accepted lower-five-bit command patterns
`define FSPC_PAT_REEN         5'h11
`define FSPC_PAT_LOCK         5'h09
`define FSPC_PAT_WRITE        5'h05
`define FSPC_PAT_ERASE        5'h03
`define FSPC_PAT_FILL         5'h01

// extra_row_mode_control field positions
`define FSPC_BIT_XROW_EXT     6
`define FSPC_XROW_SEL_HI      5
`define FSPC_XROW_SEL_LO      4

// =====================================================================
// reset values
`define FSPC_CTRL_RESET       8'h00
`define FSPC_XROW_RESET       8'h0A

// =====================================================================
// timing
`define FSPC_STORE_WINDOW     3'h4
`define FSPC_LOAD_WINDOW      2'h3
`define FSPC_CLK_MHZ          25
`define FSPC_T_WRITE_MIN_NS   3700000
`define FSPC_T_ERASE_MIN_NS   7300000
`define FSPC_WRITE_CYCLES     ((`FSPC_T_WRITE_MIN_NS * `FSPC_CLK_MHZ + 999) / 1000)
`define FSPC_ERASE_CYCLES     ((`FSPC_T_ERASE_MIN_NS * `FSPC_CLK_MHZ + 999) / 1000)

// pages in the concurrent-read section
`define FSPC_RWW_PAGES        480

`endif

// ==== src/fspc_op_timer.sv ====
// busy timer for page erase, page write and lock bit write
`timescale 1ns/1ns
`include "fspc_defs.svh"
module fspc_op_timer #(
  parameter int unsigned CNT_W         = 18,
  parameter int unsigned WRITE_CYCLES  = `FSPC_WRITE_CYCLES,
  parameter int unsigned ERASE_CYCLES  = `FSPC_ERASE_CYCLES
) (
  input  wire logic i_mclk,
  input  wire logic i_nrst,
  input  wire logic i_start,
  input  wire logic i_erase,
  output logic      o_done
);

  // =====================================================================
  // countdown
  logic [CNT_W-1:0] cnt_q;
  logic             run_q;
  wire              last = run_q && (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= last;
      if (i_start) begin
        cnt_q <= i_erase ? CNT_W'(ERASE_CYCLES) : CNT_W'(WRITE_CYCLES);
        run_q <= 1'b1;
      end else if (run_q) begin
        cnt_q <= cnt_q - 1'b1;
        run_q <= !last;
      end
    end
  end

endmodule

// ==== src/fspc_pkg.sv ====
// types shared by the flash self-program control block
package fspc_pkg;

  // =====================================================================
  // sequencer states
  typedef enum logic [1:0] {
    FSPC_IDLE,
    FSPC_ARMED,
    FSPC_BUSY
  } fspc_state_t;

  // =====================================================================
  // armed command
  typedef enum logic [2:0] {
    FSPC_CMD_NONE,
    FSPC_CMD_FILL,
    FSPC_CMD_ERASE,
    FSPC_CMD_WRITE,
    FSPC_CMD_LOCK,
    FSPC_CMD_REEN,
    FSPC_CMD_SIG
  } fspc_cmd_t;

endpackage
